/* File: logic/rtc_params.svh */
/*
 * Constants of the real-time clock: timing, register map, field places
 * and reset values.
 * Assumes inclusion by bare name from the package and design modules.
 */
`ifndef RTC_PARAMS_SVH
`define RTC_PARAMS_SVH

// Timing
`define RTC_XTAL_HZ 32768
`define RTC_TICK_HZ 1
`define RTC_PRESCALE_DIV (`RTC_XTAL_HZ / `RTC_TICK_HZ)
`define RTC_SEC_MOD 6'd60
`define RTC_MIN_MOD 6'd60
`define RTC_HOUR_MOD 5'd24

// Register byte offsets
`define RTC_OFS_TIME 8'h00
`define RTC_OFS_CTRL 8'h04
`define RTC_OFS_IEN 8'h08
`define RTC_OFS_STAT 8'h0c
`define RTC_OFS_ALM0 8'h10
`define RTC_OFS_ALM1 8'h14
`define RTC_OFS_SWLD 8'h18
`define RTC_OFS_SWCNT 8'h1c

// Time word fields
`define RTC_SEC_LSB 0
`define RTC_MIN_LSB 6
`define RTC_HOUR_LSB 12
`define RTC_DAY_LSB 17

// Event bits in the enable and status registers
`define RTC_EV_SEC 0
`define RTC_EV_MIN 1
`define RTC_EV_HOUR 2
`define RTC_EV_DAY 3
`define RTC_EV_ALM0 4
`define RTC_EV_ALM1 5
`define RTC_EV_SW 6
`define RTC_EV_N 7

// Control bits
`define RTC_CTRL_SWEN 0

// Reset values
`define RTC_RST_IEN 7'h00
`define RTC_RST_CTRL 1'b0
`define RTC_RST_SW 16'h0000

`endif

/* File: logic/rtc_pkg.sv */
/*
 * Types shared by the real-time clock modules.
 * Assumes the constants header is on the include path.
 */
`include "rtc_params.svh"

package rtc_pkg;
    typedef logic [5:0] rtc_sec_type;
    typedef logic [5:0] rtc_min_type;
    typedef logic [4:0] rtc_hour_type;
    typedef logic [14:0] rtc_day_type;
    typedef logic [15:0] rtc_sw_type;
    typedef logic [`RTC_EV_N-1:0] rtc_ev_type;
endpackage

/* File: logic/rtc_time_counter.sv */
/*
 * Cascaded seconds, minutes, hours and days counters with carry pulses.
 * Assumes tick is a one-cycle pulse once per second on hclk and that a
 * load overrides a tick in the same cycle.
 */
`include "rtc_params.svh"

module rtc_time_counter (
    // Clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // Control
    input wire logic tick,
    input wire logic load,
    input wire rtc_pkg::rtc_sec_type ld_sec,
    input wire rtc_pkg::rtc_min_type ld_min,
    input wire rtc_pkg::rtc_hour_type ld_hour,
    input wire rtc_pkg::rtc_day_type ld_day,
    // Time and tick events
    output rtc_pkg::rtc_sec_type sec,
    output rtc_pkg::rtc_min_type min,
    output rtc_pkg::rtc_hour_type hour,
    output rtc_pkg::rtc_day_type day,
    output logic sec_ev,
    output logic min_ev,
    output logic hour_ev,
    output logic day_ev
);
    import rtc_pkg::*;

    logic s_wrap;
    logic m_wrap;
    logic h_wrap;
    logic step;

    assign step = tick & ~load;
    assign s_wrap = (sec == `RTC_SEC_MOD - 6'd1);
    assign m_wrap = s_wrap & (min == `RTC_MIN_MOD - 6'd1);
    assign h_wrap = m_wrap & (hour == `RTC_HOUR_MOD - 5'd1);

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            sec <= '0;
            min <= '0;
            hour <= '0;
            day <= '0;
        end else if (load) begin
            sec <= ld_sec;
            min <= ld_min;
            hour <= ld_hour;
            day <= ld_day;
        end else if (tick) begin
            sec <= s_wrap ? 6'h00 : sec + 6'h01;
            if (s_wrap) begin
                min <= m_wrap ? 6'h00 : min + 6'h01;
            end
            if (m_wrap) begin
                hour <= h_wrap ? 5'h00 : hour + 5'h01;
            end
            if (h_wrap) begin
                // Full count rolls over to zero by width
                day <= day + 15'h0001;
            end
        end
    end

    // Events come out with the updated time, so compares see new values
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            sec_ev <= 1'b0;
            min_ev <= 1'b0;
            hour_ev <= 1'b0;
            day_ev <= 1'b0;
        end else begin
            sec_ev <= step;
            min_ev <= step & s_wrap;
            hour_ev <= step & m_wrap;
            day_ev <= step & h_wrap;
        end
    end
endmodule

/* File: logic/rtc_core.sv */
/*
 * Real-time clock top: crystal sampling and prescaler, time counters,
 * two alarms, countdown stopwatch, sticky event flags with enables,
 * interrupt and wakeup outputs, AHB-Lite register slave.
 * Assumes a single AHB-Lite master, word transfers, and a crystal clock
 * well below half of hclk so every crystal edge is seen.
 */
`include "rtc_params.svh"

module rtc_core #(
    parameter int PRESCALE_DIV = `RTC_PRESCALE_DIV
) (
    // System clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // AHB-Lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    // Crystal clock, sampled as a plain input
    input wire logic xtal_clk,
    // Event outputs
    output logic irq,
    output logic wakeup
);
    import rtc_pkg::*;

    localparam int PW = 16;
    localparam logic [PW-1:0] PRE_LAST = PW'(PRESCALE_DIV - 1);

    function automatic rtc_sec_type f_sec(input logic [31:0] w);
        f_sec = w[`RTC_SEC_LSB +: 6];
    endfunction

    function automatic rtc_min_type f_min(input logic [31:0] w);
        f_min = w[`RTC_MIN_LSB +: 6];
    endfunction

    function automatic rtc_hour_type f_hour(input logic [31:0] w);
        f_hour = w[`RTC_HOUR_LSB +: 5];
    endfunction

    function automatic rtc_day_type f_day(input logic [31:0] w);
        f_day = w[`RTC_DAY_LSB +: 15];
    endfunction

    function automatic logic [31:0] f_pack(
        input rtc_sec_type s,
        input rtc_min_type m,
        input rtc_hour_type h,
        input rtc_day_type d
    );
        f_pack = {d, h, m, s};
    endfunction

    // Crystal sampling
    logic xtal_meta;
    logic xtal_sync;
    logic xtal_prev;
    logic xtal_rise;

    // Prescaler
    logic [PW-1:0] pre_cnt;
    logic tick;

    // Bus
    logic ap_valid;
    logic ap_write;
    logic [7:0] ap_addr;
    logic wr_en;
    logic wr_time;
    logic wr_ctrl;
    logic wr_ien;
    logic wr_stat;
    logic wr_alm0;
    logic wr_alm1;
    logic wr_swld;
    logic rd_en;

    // Registers and state
    logic sw_en;
    rtc_ev_type ien;
    rtc_ev_type flag;
    rtc_ev_type ev;
    logic [31:0] alm0;
    logic [31:0] alm1;
    rtc_sw_type sw_count;
    logic sw_armed;
    logic sw_uf;

    // Time
    rtc_sec_type sec;
    rtc_min_type min;
    rtc_hour_type hour;
    rtc_day_type day;
    logic sec_ev;
    logic min_ev;
    logic hour_ev;
    logic day_ev;
    logic [31:0] time_word;
    logic alm0_hit;
    logic alm1_hit;

    // Two stages before anything looks at the crystal level
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            xtal_meta <= 1'b0;
            xtal_sync <= 1'b0;
            xtal_prev <= 1'b0;
        end else begin
            xtal_meta <= xtal_clk;
            xtal_sync <= xtal_meta;
            xtal_prev <= xtal_sync;
        end
    end

    assign xtal_rise = xtal_sync & ~xtal_prev;

    // Writing the time restarts the second so it lasts a full second
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            pre_cnt <= '0;
            tick <= 1'b0;
        end else if (wr_time) begin
            pre_cnt <= '0;
            tick <= 1'b0;
        end else begin
            tick <= 1'b0;
            if (xtal_rise) begin
                if (pre_cnt == PRE_LAST) begin
                    pre_cnt <= '0;
                    tick <= 1'b1;
                end else begin
                    pre_cnt <= pre_cnt + 16'h0001;
                end
            end
        end
    end

    rtc_time_counter u_time (
        .hclk(hclk),
        .hresetn(hresetn),
        .tick(tick),
        .load(wr_time),
        .ld_sec(f_sec(hwdata)),
        .ld_min(f_min(hwdata)),
        .ld_hour(f_hour(hwdata)),
        .ld_day(f_day(hwdata)),
        .sec(sec),
        .min(min),
        .hour(hour),
        .day(day),
        .sec_ev(sec_ev),
        .min_ev(min_ev),
        .hour_ev(hour_ev),
        .day_ev(day_ev)
    );

    assign time_word = f_pack(sec, min, hour, day);

    // Time-of-day part of an alarm word against the running time; all
    // inputs are arguments so a continuous compare follows every one
    function automatic logic f_tod_match(
        input logic [31:0] a,
        input rtc_sec_type s,
        input rtc_min_type m,
        input rtc_hour_type h
    );
        f_tod_match = s == f_sec(a) && m == f_min(a) && h == f_hour(a);
    endfunction

    // Compare only on the cycle the time has just advanced, so a match
    // fires once and not for the whole second
    assign alm0_hit = sec_ev
        && f_tod_match(alm0, sec, min, hour);
    assign alm1_hit = sec_ev && f_tod_match(alm1, sec, min, hour)
        && day == f_day(alm1);

    // Stopwatch: zero at a tick is the underflow; it fires once per load
    assign sw_uf = tick & sw_en & sw_armed & (sw_count == 16'h0000);

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            sw_count <= `RTC_RST_SW;
            sw_armed <= 1'b0;
        end else if (wr_swld) begin
            sw_count <= hwdata[15:0];
            sw_armed <= 1'b1;
        end else if (sw_uf) begin
            sw_armed <= 1'b0;
        end else if (tick & sw_en & sw_armed) begin
            sw_count <= sw_count - 16'h0001;
        end
    end

    always_comb begin
        ev = '0;
        ev[`RTC_EV_SEC] = sec_ev;
        ev[`RTC_EV_MIN] = min_ev;
        ev[`RTC_EV_HOUR] = hour_ev;
        ev[`RTC_EV_DAY] = day_ev;
        ev[`RTC_EV_ALM0] = alm0_hit;
        ev[`RTC_EV_ALM1] = alm1_hit;
        ev[`RTC_EV_SW] = sw_uf;
    end

    // Sticky flags, write one to clear; a new event beats the clear
    genvar gi;
    generate
        for (gi = 0; gi < `RTC_EV_N; gi++) begin : g_flag
            always_ff @(posedge hclk or negedge hresetn) begin
                if (!hresetn) begin
                    flag[gi] <= 1'b0;
                end else if (ev[gi]) begin
                    flag[gi] <= 1'b1;
                end else if (wr_stat & hwdata[gi]) begin
                    flag[gi] <= 1'b0;
                end
            end
        end
    endgenerate

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            irq <= 1'b0;
            wakeup <= 1'b0;
        end else begin
            irq <= |(flag & ien);
            wakeup <= |(ev & ien);
        end
    end

    // AHB-Lite address phase capture; zero wait states
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ap_valid <= 1'b0;
            ap_write <= 1'b0;
            ap_addr <= 8'h00;
        end else if (hready) begin
            ap_valid <= hsel & htrans[1];
            ap_write <= hwrite;
            ap_addr <= {haddr[7:2], 2'b00};
        end
    end

    assign wr_en = ap_valid & ap_write;
    assign wr_time = wr_en && ap_addr == `RTC_OFS_TIME;
    assign wr_ctrl = wr_en && ap_addr == `RTC_OFS_CTRL;
    assign wr_ien = wr_en && ap_addr == `RTC_OFS_IEN;
    assign wr_stat = wr_en && ap_addr == `RTC_OFS_STAT;
    assign wr_alm0 = wr_en && ap_addr == `RTC_OFS_ALM0;
    assign wr_alm1 = wr_en && ap_addr == `RTC_OFS_ALM1;
    assign wr_swld = wr_en && ap_addr == `RTC_OFS_SWLD;
    assign rd_en = hready & hsel & htrans[1] & ~hwrite;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            sw_en <= `RTC_RST_CTRL;
            ien <= `RTC_RST_IEN;
            alm0 <= '0;
            alm1 <= '0;
        end else begin
            if (wr_ctrl) begin
                sw_en <= hwdata[`RTC_CTRL_SWEN];
            end
            if (wr_ien) begin
                ien <= hwdata[`RTC_EV_N-1:0];
            end
            if (wr_alm0) begin
                alm0 <= {15'h0000, hwdata[16:0]};
            end
            if (wr_alm1) begin
                alm1 <= hwdata;
            end
        end
    end

    // Read data is fetched in the address phase so it stands for the
    // whole data phase; hsize is not checked, every access is a word
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata <= 32'h0000_0000;
        end else if (rd_en) begin
            case ({haddr[7:2], 2'b00})
                `RTC_OFS_TIME: hrdata <= time_word;
                `RTC_OFS_CTRL: hrdata <= {31'h0000_0000, sw_en};
                `RTC_OFS_IEN: hrdata <= {25'h000_0000, ien};
                `RTC_OFS_STAT: hrdata <= {25'h000_0000, flag};
                `RTC_OFS_ALM0: hrdata <= alm0;
                `RTC_OFS_ALM1: hrdata <= alm1;
                `RTC_OFS_SWLD: hrdata <= {15'h0000, sw_armed, sw_count};
                `RTC_OFS_SWCNT: hrdata <= {16'h0000, sw_count};
                default: hrdata <= 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hreadyout <= 1'b1;
            hresp <= 1'b0;
        end else begin
            hreadyout <= 1'b1;
            hresp <= 1'b0;
        end
    end
endmodule

/* File: tb/rtc_core_monitor.sv */
/*
 * Port checker for the real-time clock top.
 * Assumes one hclk domain and hreadyout fed back as hready.
 */
module rtc_core_monitor (
    // Clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // Bus
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    input wire logic hreadyout,
    input wire logic hresp,
    input wire logic [31:0] hrdata,
    // Crystal and events
    input wire logic xtal_clk,
    input wire logic irq,
    input wire logic wakeup
);
    default clocking cb @(posedge hclk);
    endclocking
    default disable iff (!hresetn);
    logic ap;
    logic xq;
    logic wr_dp;
    logic [7:0] since_rise;
    logic [7:0] since_wr;
    assign ap = hsel && hready && htrans[1];
    // Ages saturate so an old crystal edge or write never looks recent
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            xq <= 1'h0;
            wr_dp <= 1'h0;
            since_rise <= 8'hff;
            since_wr <= 8'hff;
        end else begin
            xq <= xtal_clk;
            wr_dp <= ap && hwrite;
            if (xtal_clk && !xq) since_rise <= 8'h00;
            else if (since_rise != 8'hff) since_rise <= since_rise + 8'h01;
            if (wr_dp) since_wr <= 8'h00;
            else if (since_wr != 8'hff) since_wr <= since_wr + 8'h01;
        end
    end
    sequence s_ien_addr;
        ap && hwrite && haddr[7:2] == 6'h02;
    endsequence
    sequence s_ien_zero;
        hwdata[6:0] == 7'h00;
    endsequence
    a_ready_okay: assert property (hreadyout && !hresp)
        else $error("bus slave stalled or answered an error");
    a_unmapped_zero: assert property (ap && !hwrite && haddr[7:5] != 3'h0
        |=> hrdata == 32'h0) else $error("unmapped read not zero");
    a_read_holds: assert property (!(ap && !hwrite) |=> $stable(hrdata))
        else $error("read data moved without a read");
    a_ien_clear: assert property (s_ien_addr ##1 s_ien_zero |=> ##1 !irq)
        else $error("irq stayed up with all enables off");
    a_wake_after_xtal: assert property (wakeup
        |-> since_rise >= 8'h02 && since_rise <= 8'h0c)
        else $error("wakeup without a recent crystal edge");
    a_irq_rise_cause: assert property ($rose(irq)
        |-> since_rise <= 8'h0c || since_wr <= 8'h03)
        else $error("irq rose without event or write");
    a_irq_fall_cause: assert property ($fell(irq) |-> since_wr <= 8'h03)
        else $error("irq fell without a register write");
    a_reset_quiet: assert property ($rose(hresetn)
        |-> !irq && !wakeup && hrdata == 32'h0)
        else $error("outputs not quiet after reset");
endmodule

/* File: tb/rtc_core_bench.sv */
/*
 * Self-checking bench for the real-time clock top.
 * Assumes a shortened prescaler; the bench makes crystal edges itself.
 */
module rtc_core_bench;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int DIV = 4;
    logic hclk = 1'h0;
    logic hresetn = 1'h0;
    logic hsel = 1'h0;
    logic hwrite = 1'h0;
    logic xtal_clk = 1'h0;
    logic [31:0] haddr = 32'h0;
    logic [31:0] hwdata = 32'h0;
    logic [1:0] htrans = 2'h0;
    logic [2:0] hsize = 3'h2;
    logic rd_dp = 1'h0;
    logic [31:0] rng = 32'h60f2;
    logic [31:0] expq[$];
    wire logic hready;
    wire logic hreadyout;
    wire logic hresp;
    wire logic irq;
    wire logic wakeup;
    wire logic [31:0] hrdata;
    int mismatches = 0;
    int samples_checked = 0;
    int cycles = 0;
    int wakes = 0;
    assign hready = hreadyout;
    rtc_core #(.PRESCALE_DIV(DIV)) DUT (.hclk(hclk), .hresetn(hresetn),
        .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
        .hsize(hsize), .hwdata(hwdata), .hready(hready),
        .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
        .xtal_clk(xtal_clk), .irq(irq), .wakeup(wakeup));
    initial forever #20 hclk = ~hclk;
    function automatic logic [31:0] rnd();
        rng = rng ^ (rng << 13);
        rng = rng ^ (rng >> 17);
        rng = rng ^ (rng << 5);
        return rng;
    endfunction
    function automatic logic [31:0] tw(int d, int h, int m, int s);
        return {d[14:0], h[4:0], m[5:0], s[5:0]};
    endfunction
    task automatic complete_run();
        $display("compared %0d mismatches %0d", samples_checked, mismatches);
        if (mismatches == 0 && samples_checked > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    task automatic chk(input string n, input logic [31:0] e,
                       input logic [31:0] s);
        samples_checked++;
        if (s !== e) begin
            mismatches++;
            $display("BAD %s expected %h seen %h", n, e, s);
        end
    endtask
    // Address phase held until hready, then data phase until hready
    task automatic bus(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        hsel <= 1'h1;
        htrans <= 2'h2;
        hwrite <= w;
        haddr <= {24'h0, a};
        do @(posedge hclk); while (hready !== 1'h1);
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge hclk); while (hready !== 1'h1);
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        expq.push_back(e);
        bus(1'h0, a, 32'h0);
    endtask
    // Crystal runs only inside pulse, so seconds are exact
    task automatic pulse(input int n);
        repeat (n) begin
            xtal_clk <= 1'h1;
            repeat (4) @(posedge hclk);
            xtal_clk <= 1'h0;
            repeat (4) @(posedge hclk);
        end
        repeat (8) @(posedge hclk);
        #1;
    endtask
    always @(posedge hclk) begin
        if (rd_dp) chk("hrdata", expq.pop_front(), hrdata);
        rd_dp <= hsel && hready && htrans[1] && !hwrite;
        cycles++;
        if (wakeup === 1'h1) wakes++;
        if (cycles == 20000) begin
            mismatches++;
            complete_run();
        end
    end
    initial begin
        int s;
        int w0;
        logic [31:0] r;
        repeat (10) @(posedge hclk);
        hresetn <= 1'h1;
        @(posedge hclk);
        for (int i = 0; i < 9; i++) rd(8'(i * 4), 32'h0);
        bus(1'h1, 8'h00, tw(32767, 23, 59, 58));
        pulse(DIV);
        @(posedge hclk);
        rd(8'h00, tw(32767, 23, 59, 59));
        pulse(DIV);
        @(posedge hclk);
        rd(8'h00, 32'h0);
        rd(8'h0c, 32'h3f);
        for (int i = 0; i < 3; i++) begin
            r = rnd();
            s = r[5:0] % 58;
            bus(1'h1, 8'h00, tw(r[30:16], r[20:16] % 24, r[11:6] % 60, s));
            pulse(DIV - 1);
            @(posedge hclk);
            rd(8'h00, tw(r[30:16], r[20:16] % 24, r[11:6] % 60, s));
            pulse(1);
            @(posedge hclk);
            rd(8'h00, tw(r[30:16], r[20:16] % 24, r[11:6] % 60, s + 1));
        end
        bus(1'h1, 8'h0c, 32'h7f);
        bus(1'h1, 8'h08, 32'h01);
        w0 = wakes;
        pulse(DIV);
        chk("wakeups", w0 + 1, wakes);
        chk("irq", 32'h1, irq);
        @(posedge hclk);
        bus(1'h1, 8'h08, 32'h00);
        pulse(DIV);
        chk("irq", 32'h0, irq);
        chk("wakeups", w0 + 1, wakes);
        @(posedge hclk);
        bus(1'h1, 8'h10, tw(9, 10, 20, 30));
        rd(8'h10, tw(0, 10, 20, 30));
        bus(1'h1, 8'h14, tw(6, 10, 20, 31));
        bus(1'h1, 8'h00, tw(5, 10, 20, 29));
        bus(1'h1, 8'h0c, 32'h7f);
        bus(1'h1, 8'h08, 32'h10);
        pulse(DIV);
        chk("irq", 32'h1, irq);
        @(posedge hclk);
        rd(8'h0c, 32'h11);
        pulse(DIV);
        @(posedge hclk);
        rd(8'h0c, 32'h11);
        bus(1'h1, 8'h00, tw(6, 10, 20, 30));
        pulse(DIV);
        @(posedge hclk);
        rd(8'h0c, 32'h31);
        bus(1'h1, 8'h0c, 32'h7f);
        bus(1'h1, 8'h18, 32'h2);
        bus(1'h1, 8'h04, 32'h1);
        rd(8'h04, 32'h1);
        bus(1'h1, 8'h08, 32'h40);
        rd(8'h18, 32'h10002);
        for (int i = 1; i >= 0; i--) begin
            pulse(DIV);
            @(posedge hclk);
            rd(8'h1c, i);
        end
        pulse(DIV);
        @(posedge hclk);
        rd(8'h0c, 32'h41);
        rd(8'h18, 32'h0);
        bus(1'h1, 8'h08, 32'h00);
        repeat (3) @(posedge hclk);
        complete_run();
    end
endmodule
bind rtc_core rtc_core_monitor mon (.hclk(hclk), .hresetn(hresetn),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hwdata(hwdata), .hready(hready),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
    .xtal_clk(xtal_clk), .irq(irq), .wakeup(wakeup));
